/* rtl/refresh_controller.sv */
/*
  Controller end: schedules all-bank and single-bank refreshes,
  activates and precharges, and enforces every separation and the
  pull-in limit before driving a command; at the postpone limit it only raises REFRESH_URGENT.
  Assumes one request at a time from the user side; a request stands
  until its grant pulse.
*/
`timescale 1ns/1ps
module refresh_controller
  import refresh_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // user requests, held until granted
  input wire logic REQ_ALL,
  input wire logic REQ_ONE,
  input wire logic REQ_ACT,
  input wire logic REQ_PRE,
  input wire logic REQ_PRE_ALL,
  input wire logic REQ_RESET,
  input wire logic REQ_SR_EXIT,
  input wire logic [BANK_W-1:0] REQ_BANK,
  // answers
  output logic GRANT,
  output logic [BANK_W-1:0] NEXT_BANK,
  output logic signed [CREDIT_W-1:0] CREDIT,
  output logic REFRESH_URGENT,
  // link
  refresh_if.controller LINK
);

  typedef struct packed {
    logic [BANK_W-1:0] ptr;
    logic [NUM_BANKS-1:0] open;
    logic [TIMER_W-1:0] rfc_all;
    logic [TIMER_W-1:0] rfc_one;
    logic [TIMER_W-1:0] act_gap;
    logic [NUM_BANKS-1:0][TIMER_W-1:0] pre_gap;
    logic [NUM_BANKS-1:0][TIMER_W-1:0] bank_gap;
    logic [TIMER_W-1:0] tick;
    logic tick_half;
    logic signed [CREDIT_W-1:0] credit;
    logic [BANK_W-1:0] one_cnt;
    logic [WIN_W-1:0] win_prev;
    logic [WIN_W-1:0] win_cur;
    logic grant;
    logic cs_n;
    logic [CA_W-1:0] ca;
    logic [BANK_W-1:0] bank;
    logic act;
    logic pre;
    logic pre_all;
    logic rst;
    logic srx;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;
  logic pre_clear;
  logic ok_all;
  logic ok_one;
  logic ok_act;
  logic refresh_done;
  logic tick_now;

  // --------------------------------------------------
  // issue conditions
  // --------------------------------------------------
  always_comb begin
    pre_clear = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (s_r.pre_gap[i] != '0) begin
        pre_clear = 1'b0;
      end
    end
    // pulled-in credit stops at the floor
    ok_all = (s_r.open == '0) && (s_r.rfc_all == '0) &&
             (s_r.rfc_one == '0) && pre_clear &&
             (s_r.credit != CREDIT_MIN) &&
             ((s_r.win_prev + s_r.win_cur) < WIN_W'(WIN_LIMIT));
    ok_one = !s_r.open[s_r.ptr] && (s_r.rfc_all == '0) &&
             (s_r.rfc_one == '0) && (s_r.act_gap == '0) &&
             (s_r.pre_gap[s_r.ptr] == '0) &&
             !((s_r.credit == CREDIT_MIN) && (s_r.one_cnt == BANK_LAST));
    // only the refreshing bank blocks its own activate
    ok_act = (s_r.rfc_all == '0) && (s_r.act_gap == '0) &&
             (s_r.bank_gap[REQ_BANK] == '0) &&
             (s_r.pre_gap[REQ_BANK] == '0) && !s_r.open[REQ_BANK];
  end

  assign tick_now = (s_r.tick == '0);

  // --------------------------------------------------
  // arbitration and bookkeeping
  // --------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    refresh_done = 1'b0;
    s_nxt.grant = 1'b0;
    s_nxt.cs_n = 1'b1;
    s_nxt.ca = '0;
    s_nxt.act = 1'b0;
    s_nxt.pre = 1'b0;
    s_nxt.pre_all = 1'b0;
    s_nxt.rst = 1'b0;
    s_nxt.srx = 1'b0;
    s_nxt.bank = REQ_BANK;
    // countdowns
    if (s_r.rfc_all != '0) s_nxt.rfc_all = s_r.rfc_all - 1'b1;
    if (s_r.rfc_one != '0) s_nxt.rfc_one = s_r.rfc_one - 1'b1;
    if (s_r.act_gap != '0) s_nxt.act_gap = s_r.act_gap - 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (s_r.pre_gap[i] != '0) s_nxt.pre_gap[i] = s_r.pre_gap[i] - 1'b1;
      if (s_r.bank_gap[i] != '0) begin
        s_nxt.bank_gap[i] = s_r.bank_gap[i] - 1'b1;
      end
    end
    // interval ticker; the window covers two intervals
    s_nxt.tick = tick_now ? TIMER_W'(T_REFI - 1) : s_r.tick - 1'b1;
    if (tick_now) begin
      s_nxt.tick_half = !s_r.tick_half;
      if (s_r.tick_half) begin
        s_nxt.win_prev = s_r.win_cur;
        s_nxt.win_cur = '0;
      end
    end
    // one request per cycle, held until granted; a grant blocks the
    // next cycle so the held request is not taken twice
    if (s_r.grant) begin
      s_nxt.grant = 1'b0;
    end else if (REQ_RESET) begin
      s_nxt.rst = 1'b1;
      s_nxt.ptr = BANK_ZERO;
      s_nxt.one_cnt = BANK_ZERO;
      s_nxt.open = '0;
      s_nxt.grant = 1'b1;
    end else if (REQ_SR_EXIT) begin
      s_nxt.srx = 1'b1;
      s_nxt.ptr = BANK_ZERO;
      s_nxt.one_cnt = BANK_ZERO;
      s_nxt.grant = 1'b1;
    end else if (REQ_ALL && ok_all) begin
      s_nxt.cs_n = 1'b0;
      s_nxt.ca = {1'b1, REFRESH_CODE};
      s_nxt.rfc_all = TIMER_W'(T_RFC_ALL);
      s_nxt.ptr = BANK_ZERO;
      s_nxt.one_cnt = BANK_ZERO;
      s_nxt.win_cur = s_r.win_cur + 1'b1;
      refresh_done = 1'b1;
      s_nxt.grant = 1'b1;
    end else if (REQ_ONE && ok_one) begin
      s_nxt.cs_n = 1'b0;
      s_nxt.ca = {1'b0, REFRESH_CODE};
      s_nxt.rfc_one = TIMER_W'(T_RFC_ONE);
      s_nxt.act_gap = TIMER_W'(T_ACT_ACT);
      s_nxt.bank_gap[s_r.ptr] = TIMER_W'(T_RFC_ONE);
      s_nxt.ptr = (s_r.ptr == BANK_LAST) ? BANK_ZERO
                  : s_r.ptr + BANK_ONE;
      s_nxt.one_cnt = (s_r.one_cnt == BANK_LAST) ? BANK_ZERO
                      : s_r.one_cnt + BANK_ONE;
      refresh_done = (s_r.one_cnt == BANK_LAST);
      if (refresh_done) s_nxt.win_cur = s_r.win_cur + 1'b1;
      s_nxt.grant = 1'b1;
    end else if (REQ_ACT && ok_act) begin
      s_nxt.act = 1'b1;
      s_nxt.open[REQ_BANK] = 1'b1;
      s_nxt.act_gap = TIMER_W'(T_ACT_ACT);
      s_nxt.grant = 1'b1;
    end else if (REQ_PRE) begin
      s_nxt.pre = 1'b1;
      s_nxt.open[REQ_BANK] = 1'b0;
      s_nxt.pre_gap[REQ_BANK] = TIMER_W'(T_PRE);
      s_nxt.grant = 1'b1;
    end else if (REQ_PRE_ALL) begin
      s_nxt.pre_all = 1'b1;
      s_nxt.open = '0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        s_nxt.pre_gap[i] = TIMER_W'(T_PRE);
      end
      s_nxt.grant = 1'b1;
    end
    // credit: tick owes one, refresh pays one; clamp
    if (tick_now && !refresh_done && s_r.credit != CREDIT_MAX) begin
      s_nxt.credit = s_r.credit + CREDIT_ONE;
    end else if (!tick_now && refresh_done) begin
      s_nxt.credit = s_r.credit - CREDIT_ONE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
      s_r.cs_n <= 1'b1;
      s_r.tick <= TIMER_W'(T_REFI - 1);
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign GRANT = s_r.grant;
  assign NEXT_BANK = s_r.ptr;
  assign CREDIT = s_r.credit;
  // eight owed: refresh must go before the next tick
  assign REFRESH_URGENT = (s_r.credit == CREDIT_MAX);
  assign LINK.cs_n = s_r.cs_n;
  assign LINK.ca = s_r.ca;
  assign LINK.act_bank = s_r.bank;
  assign LINK.act_cmd = s_r.act;
  assign LINK.pre_cmd = s_r.pre;
  assign LINK.pre_all_cmd = s_r.pre_all;
  assign LINK.reset_cmd = s_r.rst;
  assign LINK.sr_exit = s_r.srx;

endmodule

/* common/refresh_pkg.sv */
/*
  Shared constants and types for the refresh-scheduling link between a
  memory controller end and the memory device end.
  Assumes one 250 MHz clock shared by both ends and an active-low reset.
*/
package refresh_pkg;

  // ---------------------------------------------------------------
  // command encoding on chip select and the low command lines
  // ---------------------------------------------------------------
  localparam int CA_W = 4;
  localparam logic [2:0] REFRESH_CODE = 3'h4; // ca2 high, ca1/ca0 low
  localparam int SEL_BIT = 3;                 // low: single bank

  // ---------------------------------------------------------------
  // bank counter
  // ---------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;
  localparam logic [BANK_W-1:0] BANK_ONE = 3'h1;
  localparam logic [BANK_W-1:0] BANK_LAST = 3'h7;

  // ---------------------------------------------------------------
  // timing, in ns and derived cycles at 4 ns per clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int ALL_BANK_REFRESH_CYCLE_TIME_NS = 130;
  localparam int SINGLE_BANK_REFRESH_CYCLE_TIME_NS = 60;
  localparam int ACTIVATE_TO_ACTIVATE_SPACING_NS = 10;
  localparam int PRECHARGE_TIME_NS = 18;
  localparam int AVERAGE_REFRESH_INTERVAL_NS = 3900;
  // least times round up
  localparam int T_RFC_ALL = (ALL_BANK_REFRESH_CYCLE_TIME_NS
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RFC_ONE = (SINGLE_BANK_REFRESH_CYCLE_TIME_NS
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_ACT_ACT = (ACTIVATE_TO_ACTIVATE_SPACING_NS
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PRE = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
                         / CLK_PERIOD_NS;
  // the interval is an average: round down
  localparam int T_REFI = AVERAGE_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  // ---------------------------------------------------------------
  // postpone and pull-in limits
  // ---------------------------------------------------------------
  localparam int CREDIT_W = 5;
  localparam logic signed [CREDIT_W-1:0] CREDIT_MAX = 5'sh08;
  localparam logic signed [CREDIT_W-1:0] CREDIT_MIN = -5'sh08;
  localparam logic signed [CREDIT_W-1:0] CREDIT_ONE = 5'sh01;
  localparam logic signed [CREDIT_W-1:0] CREDIT_ZERO = 5'sh00;
  localparam int WIN_LIMIT = 16;   // all-bank commands per two intervals
  localparam int WIN_W = 8;

  typedef enum logic [1:0] {
    BANK_IDLE = 2'b00,
    BANK_OPEN = 2'b01,
    BANK_REFRESHING = 2'b10
  } bank_state_t;

endpackage

/* common/refresh_if.sv */
/*
  Command/address link between controller and memory device.
  Assumes both ends share CLK; signals sampled on the rising edge.
*/
`timescale 1ns/1ps
interface refresh_if;
  import refresh_pkg::*;
  logic cs_n;                 // chip select, active low
  logic [CA_W-1:0] ca;        // command lines
  logic [BANK_W-1:0] act_bank; // bank of an activate/precharge
  logic act_cmd;              // activate strobe
  logic pre_cmd;              // single-bank precharge strobe
  logic pre_all_cmd;          // precharge-all strobe
  logic reset_cmd;            // reset command
  logic sr_exit;              // exit from self refresh

  modport controller (output cs_n, ca, act_bank, act_cmd, pre_cmd,
                      pre_all_cmd, reset_cmd, sr_exit);
  modport memory (input cs_n, ca, act_bank, act_cmd, pre_cmd,
                  pre_all_cmd, reset_cmd, sr_exit);
endinterface

/* rtl/bank_timer.sv */
/*
  Down-counter that says when a fixed separation has passed.
  Assumes start pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
module bank_timer
  import refresh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic [TIMER_W-1:0] load,
  // status
  output logic done
);

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
  } timer_state_t;

  timer_state_t s_r;
  timer_state_t s_nxt;

  // --------------------------------------------------
  // count down; a new start restarts the wait
  // --------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (start) begin
      s_nxt.cnt = load;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = (s_r.cnt == '0);

endmodule

/* rtl/refresh_memory.sv */
/*
  Memory device end: decodes refresh commands, keeps the round-robin
  bank counter and per-bank busy/idle state.
  Assumes the controller keeps all separations; activates of a busy bank and refreshes of an open bank are flagged.
*/
`timescale 1ns/1ps
module refresh_memory
  import refresh_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // link
  refresh_if.memory LINK,
  // user side status
  output logic [BANK_W-1:0] BANK_PTR,
  output logic [NUM_BANKS-1:0] BANK_BUSY,
  output logic [NUM_BANKS-1:0] BANK_OPEN_MAP,
  output logic REFRESH_SEEN,
  output logic ACCESS_ERROR
);

  typedef struct packed {
    logic [BANK_W-1:0] ptr;
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0] busy;
    logic seen;
    logic err;
  } mem_state_t;

  mem_state_t s_r;
  mem_state_t s_nxt;
  logic is_ref;
  logic is_one;
  logic is_all;
  logic [NUM_BANKS-1:0] timer_start;
  logic [NUM_BANKS-1:0] timer_done;
  logic [TIMER_W-1:0] timer_load;

  // --------------------------------------------------
  // decode
  // --------------------------------------------------
  assign is_ref = !LINK.cs_n && (LINK.ca[2:0] == REFRESH_CODE);
  assign is_one = is_ref && !LINK.ca[SEL_BIT];
  assign is_all = is_ref && LINK.ca[SEL_BIT];
  assign timer_load = is_all ? TIMER_W'(T_RFC_ALL) : TIMER_W'(T_RFC_ONE);

  // one refresh-cycle timer per bank
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      assign timer_start[g] = is_all || (is_one && s_r.ptr == g);
      bank_timer u_timer (
        .clk(CLK),
        .nrst(NRST),
        .start(timer_start[g]),
        .load(timer_load),
        .done(timer_done[g])
      );
    end
  endgenerate

  // --------------------------------------------------
  // bank state and counter update
  // --------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.seen = is_ref;
    // finished cycles leave banks idle
    s_nxt.busy = s_r.busy & ~timer_done;
    // reset command clears first so an error in the same cycle still sets
    if (LINK.reset_cmd) begin
      s_nxt.open = '0;
      s_nxt.err = 1'b0;
    end
    if (LINK.act_cmd) begin
      // only the refreshing bank refuses; others stay usable
      // a bank whose timer ran out this cycle is already free
      if (s_r.busy[LINK.act_bank] && !timer_done[LINK.act_bank]) begin
        s_nxt.err = 1'b1;
      end else begin
        s_nxt.open[LINK.act_bank] = 1'b1;
      end
    end
    if (LINK.pre_cmd) begin
      s_nxt.open[LINK.act_bank] = 1'b0;
    end
    if (LINK.pre_all_cmd) begin
      s_nxt.open = '0;
    end
    if (is_one) begin
      if (s_r.open[s_r.ptr]) begin
        s_nxt.err = 1'b1;
      end
      s_nxt.busy[s_r.ptr] = 1'b1;
      s_nxt.ptr = (s_r.ptr == BANK_LAST) ? BANK_ZERO
                  : s_r.ptr + BANK_ONE;
    end
    if (is_all) begin
      if (s_r.open != '0) begin
        s_nxt.err = 1'b1;
      end
      s_nxt.busy = '1;
      s_nxt.open = '0;
      s_nxt.ptr = BANK_ZERO;
    end
    // counter resync has final say
    if (LINK.reset_cmd || LINK.sr_exit) begin
      s_nxt.ptr = BANK_ZERO;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------
  // outputs straight from state
  // --------------------------------------------------
  assign BANK_PTR = s_r.ptr;
  assign BANK_BUSY = s_r.busy;
  assign BANK_OPEN_MAP = s_r.open;
  assign REFRESH_SEEN = s_r.seen;
  assign ACCESS_ERROR = s_r.err;

endmodule

/* tb/refresh_properties.sv */
/*
  Concurrent checks on the command link between the two ends.
  Assumes the link signals and the shared clock and reset are wired in
  by name from the bench's top module.
*/
`timescale 1ns/1ps
module refresh_properties
  import refresh_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // link
  input wire logic cs_n,
  input wire logic [CA_W-1:0] ca,
  input wire logic [BANK_W-1:0] act_bank,
  input wire logic act_cmd,
  input wire logic pre_cmd,
  input wire logic pre_all_cmd,
  input wire logic reset_cmd,
  input wire logic sr_exit
);
  // ---------------------------------------------------------------
  // link mirror: cycles since each refresh kind, activate and precharge, counter, open banks
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TIMER_W-1:0] since_all;
    logic [TIMER_W-1:0] since_one;
    logic [TIMER_W-1:0] since_act;
    logic [TIMER_W-1:0] since_pre;
    logic [BANK_W-1:0] ptr;
    logic [BANK_W-1:0] one_bank;
    logic [NUM_BANKS-1:0] open;
  } mirror_t;
  mirror_t m_r;
  mirror_t m_nxt;
  logic ref_all;
  logic ref_one;
  assign ref_all = !cs_n && ca[SEL_BIT];
  assign ref_one = !cs_n && !ca[SEL_BIT];

  // counters saturate so a long quiet spell never wraps into a hazard
  function automatic logic [TIMER_W-1:0] bump(input logic [TIMER_W-1:0] v);
    return (&v) ? v : v + 12'h001;
  endfunction

  // next mirror state from this cycle's command
  always_comb begin
    m_nxt = m_r;
    m_nxt.since_all = ref_all ? 12'h001 : bump(m_r.since_all);
    m_nxt.since_one = ref_one ? 12'h001 : bump(m_r.since_one);
    m_nxt.since_act = act_cmd ? 12'h001 : bump(m_r.since_act);
    m_nxt.since_pre = (pre_cmd || pre_all_cmd) ? 12'h001
                      : bump(m_r.since_pre);
    if (act_cmd) m_nxt.open[act_bank] = 1'b1;
    if (pre_cmd) m_nxt.open[act_bank] = 1'b0;
    if (pre_all_cmd || reset_cmd) m_nxt.open = 8'h00;
    if (ref_one) begin
      m_nxt.ptr = m_r.ptr + 3'h1;
      m_nxt.one_bank = m_r.ptr;
    end
    if (ref_all || reset_cmd || sr_exit) m_nxt.ptr = BANK_ZERO;
  end

  // after reset every separation counts as long since met
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) m_r <= {{4{12'hfff}}, 3'h0, 3'h0, 8'h00};
    else m_r <= m_nxt;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_code_frame: assert property (!cs_n |-> ca[2:0] == REFRESH_CODE)
    else $error("refresh frame with wrong command code");
  a_frame_one_cycle: assert property (!cs_n |=> cs_n)
    else $error("refresh command held longer than one cycle");
  a_one_command: assert property ($onehot0({!cs_n, act_cmd, pre_cmd,
    pre_all_cmd, reset_cmd, sr_exit}))
    else $error("two commands on the link in one cycle");
  a_target_idle: assert property (ref_one |-> !m_r.open[m_r.ptr])
    else $error("single-bank refresh of an open bank");
  a_all_idle: assert property (ref_all |-> m_r.open == 8'h00)
    else $error("all-bank refresh with a bank open");
  a_all_spacing: assert property (ref_all |-> m_r.since_all >= T_RFC_ALL
    && m_r.since_one >= T_RFC_ONE && m_r.since_pre >= T_PRE)
    else $error("all-bank refresh too soon");
  a_one_spacing: assert property (ref_one |-> m_r.since_all >= T_RFC_ALL
    && m_r.since_one >= T_RFC_ONE && m_r.since_act >= T_ACT_ACT)
    else $error("single-bank refresh too soon");
  a_act_spacing: assert property (act_cmd |-> m_r.since_all >= T_RFC_ALL
    && m_r.since_act >= T_ACT_ACT && m_r.since_one >=
    ((act_bank == m_r.one_bank) ? T_RFC_ONE : T_ACT_ACT))
    else $error("activate too soon after refresh or activate");
endmodule

/* tb/sdram_refresh_scheduling_tb.sv */
/*
  Self-checking bench: controller end and memory end face each other.
  Assumes refresh_properties watches the link; inputs change at falling
  edges, refresh results are checked by a queue-driven monitor.
*/
`timescale 1ns/1ps
module sdram_refresh_scheduling_tb;
  import refresh_pkg::*;
  typedef struct packed {
    logic [7:0] busy;
    logic [2:0] ptr;
  } note_t;
  logic clk;
  logic nrst;
  logic [6:0] reqv;
  logic [BANK_W-1:0] req_bank;
  logic grant;
  logic urgent;
  logic seen;
  logic acc_err;
  logic [BANK_W-1:0] next_bank;
  logic [BANK_W-1:0] bank_ptr;
  logic [BANK_W-1:0] exp_ptr;
  logic [BANK_W-1:0] p;
  logic [BANK_W-1:0] q;
  logic signed [CREDIT_W-1:0] credit;
  logic [NUM_BANKS-1:0] busy;
  logic [NUM_BANKS-1:0] open_map;
  note_t notes[$];
  note_t nt;
  int n_fail;
  int checks;
  int n;
  int rnd;

  refresh_if i_refresh_if();
  refresh_controller i_refresh_controller(.CLK(clk), .NRST(nrst),
    .REQ_ALL(reqv[0]), .REQ_ONE(reqv[1]), .REQ_ACT(reqv[2]),
    .REQ_PRE(reqv[3]), .REQ_PRE_ALL(reqv[4]), .REQ_RESET(reqv[5]),
    .REQ_SR_EXIT(reqv[6]), .REQ_BANK(req_bank), .GRANT(grant),
    .NEXT_BANK(next_bank), .CREDIT(credit), .REFRESH_URGENT(urgent),
    .LINK(i_refresh_if));
  refresh_memory i_refresh_memory(.CLK(clk), .NRST(nrst),
    .LINK(i_refresh_if), .BANK_PTR(bank_ptr), .BANK_BUSY(busy),
    .BANK_OPEN_MAP(open_map), .REFRESH_SEEN(seen),
    .ACCESS_ERROR(acc_err));
  refresh_properties i_refresh_properties(.CLK(clk), .NRST(nrst),
    .cs_n(i_refresh_if.cs_n), .ca(i_refresh_if.ca),
    .act_bank(i_refresh_if.act_bank), .act_cmd(i_refresh_if.act_cmd),
    .pre_cmd(i_refresh_if.pre_cmd), .pre_all_cmd(i_refresh_if.pre_all_cmd),
    .reset_cmd(i_refresh_if.reset_cmd), .sr_exit(i_refresh_if.sr_exit));

  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // kinds: 0 all, 1 single, 2 act, 3 pre, 4 pre-all, 5 reset, 6 sr exit;
  // the request is held until the grant pulse, then dropped at once
  task automatic req(input int kind, input logic [2:0] bank);
    int k;
    k = 0;
    @(negedge clk);
    if (kind == 0) notes.push_back({8'hff, 3'h0});
    if (kind == 1) notes.push_back({8'h01 << exp_ptr, exp_ptr + 3'h1});
    reqv = 7'h01 << kind;
    req_bank = bank;
    do begin
      @(negedge clk);
      k++;
    end while (grant !== 1'b1 && k < 2000);
    reqv = 7'h00;
    if (k >= 2000) n_fail++;
    if (kind < 2) begin
      exp_ptr = (kind == 0) ? 3'h0 : exp_ptr + 3'h1;
      chk({5'h0, next_bank}, {5'h0, exp_ptr});
    end
    if (kind >= 5) exp_ptr = 3'h0;
  endtask

  // ---------------------------------------------------------------
  // monitor: each refresh seen by the device consumes the oldest note
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (seen === 1'b1) begin
      if (notes.size() == 0) begin
        chk(8'h00, 8'h01);
      end else begin
        nt = notes.pop_front();
        chk(busy & nt.busy, nt.busy);
        chk({5'h0, bank_ptr}, {5'h0, nt.ptr});
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reqv = 7'h00;
    req_bank = 3'h0;
    exp_ptr = 3'h0;
    n_fail = 0;
    checks = 0;
    rnd = $urandom(4298);
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({3'h0, credit}, 8'h00);
    // owed count climbs one per interval and reaches eight
    repeat (8 * T_REFI + T_REFI / 2) @(negedge clk);
    chk({3'h0, credit}, 8'h08);
    chk({7'h0, urgent}, 8'h01);
    req(0, 3'h0);
    @(negedge clk);
    chk({3'h0, credit}, 8'h07);
    chk({7'h0, urgent}, 8'h00);
    repeat (40) @(negedge clk);
    chk(busy, 8'h00);
    // random-length run of singles so the counter wraps past seven
    n = 9 + int'($urandom % 4);
    for (int i = 0; i < n; i++) req(1, 3'h0);
    repeat (20) @(negedge clk);
    chk(busy, 8'h00);
    // both synchronising commands put the device counter back to zero
    req(5, 3'h0);
    req(1, 3'h0);
    req(1, 3'h0);
    req(6, 3'h0);
    repeat (2) @(negedge clk);
    chk({5'h0, bank_ptr}, 8'h00);
    // another bank opens while one is in its refresh cycle
    p = exp_ptr;
    q = p + 3'h1 + 3'($urandom % 7);
    req(1, 3'h0);
    req(2, q);
    repeat (2) @(negedge clk);
    chk(open_map, 8'h01 << q);
    chk(busy & (8'h01 << p), 8'h01 << p);
    req(3, q);
    repeat (2) @(negedge clk);
    chk(open_map, 8'h00);
    req(2, q);
    req(2, p);
    req(4, 3'h0);
    repeat (2) @(negedge clk);
    chk(open_map, 8'h00);
    req(0, 3'h0);
    // activate at the earliest edge the all-bank cycle allows
    req(2, 3'h0);
    repeat (40) @(negedge clk);
    chk(busy, 8'h00);
    chk(open_map, 8'h01);
    chk({7'h0, acc_err}, 8'h00);
    end_sim;
  end

  // hang guard: the sequence needs about 8,700 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule
